// >>> pkg/rtc_irq_pkg.sv
// constants for the rtc reset and interrupt-request block
// assumes a 200 mhz pclk and an apb master with 32-bit data
`default_nettype none

package rtc_irq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// bus widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	////////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00; // interrupt enables, square-wave enable
	localparam logic [7:0] ADDR_FLAGS  = 8'h04; // event flags, cleared by read
	localparam logic [7:0] ADDR_ISTAT  = 8'h08; // sticky interrupt status, write one to clear
	localparam logic [7:0] ADDR_IMASK  = 8'h0c; // interrupt mask, same layout as status
	localparam logic [7:0] ADDR_STATE  = 8'h10; // live block state, read only
	localparam logic [7:0] ADDR_TIME   = 8'h14; // timekeeping count
	localparam logic [7:0] ADDR_RAM    = 8'h20; // first word of general ram
	localparam logic [7:0] RAM_MASK    = 8'hf0; // ram occupies 0x20..0x2c
	localparam int unsigned RAM_WORDS  = 4;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned NUM_EV        = 3;
	localparam int unsigned EV_PERIODIC   = 0; // periodic event / enable
	localparam int unsigned EV_ALARM      = 1; // alarm event / enable
	localparam int unsigned EV_UPDATE     = 2; // update-done event / enable
	localparam int unsigned CTRL_SQUARE_WAVE_ENABLE     = 3; // square_wave_enable
	localparam int unsigned FLAG_SUMMARY  = 7; // summary_request_flag
	localparam int unsigned NUM_IS        = 3;
	localparam int unsigned IS_REQUEST    = 0; // new interrupt request raised
	localparam int unsigned IS_DEV_RESET  = 1; // reset pin went low
	localparam int unsigned IS_POWER_FAIL = 2; // supply fell below power_fail_threshold
	localparam int unsigned ST_RESET      = 0; // reset pin low
	localparam int unsigned ST_POWER_FAIL = 1; // power fail present
	localparam int unsigned ST_POWERUP    = 2; // power-up timer expired
	localparam int unsigned ST_IRQ        = 3; // request line pulled low

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [2:0] EN_RST    = 3'h0;
	localparam logic [2:0] FLAG_RST  = 3'h0;
	localparam logic [2:0] IMASK_RST = 3'h0;
	localparam logic [2:0] ISTAT_RST = 3'h0;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_MHZ    = 200;
	localparam int unsigned POWERUP_MS = 200; // power-up timer length
	localparam int unsigned POWERUP_CYCLES_DEF = POWERUP_MS * 1000 * CLK_MHZ;
	localparam int unsigned PU_CNT_W   = 26;

endpackage

`default_nettype wire

// >>> logic/pin_sync3.sv
// three-stage synchroniser for a level arriving from a pin
// assumes the level is slow against pclk; output moves once stages two and three agree
`default_nettype none

module pin_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_in,
	output var  logic level_out
);

	logic stage1_r;
	logic stage2_r;
	logic stage3_r;

	////////////////////////////////////////////////////////////////////////////
	// shift chain; stage1 feeds only stage2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_r <= RST_VAL;
			stage2_r <= RST_VAL;
			stage3_r <= RST_VAL;
		end else begin
			stage1_r <= pin_in;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
		end
	end

	// accept a new level only when the two late stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_out <= RST_VAL;
		end else if (stage2_r == stage3_r) begin
			level_out <= stage3_r;
		end
	end

endmodule

`default_nettype wire

// >>> logic/rtc_irq_ctrl.sv
// rtc reset-pin and interrupt-request logic with an apb register port
// assumes event pulses arrive on pclk; reset and power-fail pins are asynchronous
//
// Contract
// - reset pin leaves timekeeping count and general ram untouched
// - reset low with good supply clears the three interrupt enables
// - reset low with good supply clears three event flags and summary flag
// - reset low with good supply releases the request line
// - bus accesses are ignored while reset pin is low
// - reset low with good supply clears square_wave_enable
// - power fail alone never alters control registers
// - request line held low while any flag and its enable are set
// - reading the flag register clears pending flags, releasing the line
// - request line is open drain: pulls low or floats
// - below power_fail_threshold no bus access reaches registers or ram
//
// Register access over APB and the register offsets are this design's own decisions.
`default_nettype none

module rtc_irq_ctrl
	import rtc_irq_pkg::*;
#(
	parameter int unsigned POWERUP_CYCLES = rtc_irq_pkg::POWERUP_CYCLES_DEF
) (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [rtc_irq_pkg::ADDR_W-1:0] paddr,
	input  wire logic [rtc_irq_pkg::DATA_W-1:0] pwdata,
	output var  logic [rtc_irq_pkg::DATA_W-1:0] prdata,
	output var  logic                         pready,
	output var  logic                         pslverr,
	input  wire logic                         reset_pin_n,
	input  wire logic                         power_fail_pin,
	input  wire logic                         periodic_tick,
	input  wire logic                         alarm_match,
	input  wire logic                         update_done,
	output var  logic                         irq_req_n_out,
	output var  logic                         irq_req_n_oe,
	output var  logic                         square_wave_en,
	output var  logic                         intr
);

	import rtc_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic                  reset_pin_n_s;
	logic                  power_fail_s;
	logic                  dev_reset;
	logic                  reset_clear;
	logic                  blocked;
	logic [PU_CNT_W-1:0]   pu_count_r;
	logic                  powerup_done_r;
	logic [NUM_EV-1:0]     int_en_r;
	logic [NUM_EV-1:0]     ev_flag_r;
	logic [NUM_EV-1:0]     ev_in;
	logic                  summary_r;
	logic                  summary_set;
	logic [NUM_IS-1:0]     istat_r;
	logic [NUM_IS-1:0]     imask_r;
	logic [NUM_IS-1:0]     is_event;
	logic                  dev_reset_d_r;
	logic                  power_fail_d_r;
	logic [DATA_W-1:0]     time_count_r;
	logic [DATA_W-1:0]     ram_r [RAM_WORDS];
	logic                  acc_start;
	logic                  acc_commit;
	logic                  acc_ok_r;
	logic                  hit;
	logic [DATA_W-1:0]     rd_mux;
	logic                  wr_now;
	logic                  flag_read;
	logic                  is_ram;
	logic [1:0]            ram_idx;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	pin_sync3 #(
		.RST_VAL (1'b1)
	) u_sync_reset (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    (reset_pin_n),
		.level_out (reset_pin_n_s)
	);

	pin_sync3 #(
		.RST_VAL (1'b0)
	) u_sync_pfail (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    (power_fail_pin),
		.level_out (power_fail_s)
	);

	// reset pin only clears control state while the supply is good
	assign dev_reset   = ~reset_pin_n_s;
	assign reset_clear = dev_reset & ~power_fail_s;

	////////////////////////////////////////////////////////////////////////////
	// power-up timer; the bus stays shut until it expires
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_count_r     <= '0;
			powerup_done_r <= 1'b0;
		end else if (!powerup_done_r) begin
			if (pu_count_r >= PU_CNT_W'(POWERUP_CYCLES - 1)) begin
				powerup_done_r <= 1'b1;
			end else begin
				pu_count_r <= pu_count_r + PU_CNT_W'(1);
			end
		end
	end

	// accesses are refused under reset, power fail or before power-up
	assign blocked = dev_reset | power_fail_s | ~powerup_done_r;

	////////////////////////////////////////////////////////////////////////////
	// apb handshake: answer one cycle into the access phase
	assign acc_start  = psel & penable & ~pready;
	assign acc_commit = psel & penable & pready;
	assign is_ram     = (paddr & RAM_MASK) == ADDR_RAM;
	assign ram_idx    = paddr[3:2];

	// address decode and read data
	always_comb begin
		hit    = 1'b1;
		rd_mux = '0;
		if (is_ram && paddr[1:0] == 2'h0) begin
			rd_mux = ram_r[ram_idx];
		end else begin
			unique case (paddr)
				ADDR_CTRL: begin
					rd_mux[NUM_EV-1:0] = int_en_r;
					rd_mux[CTRL_SQUARE_WAVE_ENABLE]  = square_wave_en;
				end
				ADDR_FLAGS: begin
					rd_mux[NUM_EV-1:0]   = ev_flag_r;
					rd_mux[FLAG_SUMMARY] = summary_r;
				end
				ADDR_ISTAT: rd_mux[NUM_IS-1:0] = istat_r;
				ADDR_IMASK: rd_mux[NUM_IS-1:0] = imask_r;
				ADDR_STATE: begin
					rd_mux[ST_RESET]      = dev_reset;
					rd_mux[ST_POWER_FAIL] = power_fail_s;
					rd_mux[ST_POWERUP]    = powerup_done_r;
					rd_mux[ST_IRQ]        = irq_req_n_oe;
				end
				ADDR_TIME: rd_mux = time_count_r;
				default:   hit = 1'b0;
			endcase
		end
	end

	// answer registers; a refused access reads zero and flags an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= '0;
			acc_ok_r <= 1'b0;
		end else if (acc_start) begin
			pready   <= 1'b1;
			acc_ok_r <= hit & ~blocked;
			pslverr  <= ~hit | blocked;
			prdata   <= (hit && !blocked && !pwrite) ? rd_mux : '0;
		end else begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			acc_ok_r <= 1'b0;
		end
	end

	// effects land on the edge where the master sees pready
	assign wr_now    = acc_commit & acc_ok_r & pwrite;
	assign flag_read = acc_commit & acc_ok_r & ~pwrite & (paddr == ADDR_FLAGS);

	////////////////////////////////////////////////////////////////////////////
	// control register: interrupt enables and square-wave enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_en_r       <= EN_RST;
			square_wave_en <= 1'b0;
		end else if (reset_clear) begin
			int_en_r       <= EN_RST;
			square_wave_en <= 1'b0;
		end else if (wr_now && paddr == ADDR_CTRL) begin
			int_en_r       <= pwdata[NUM_EV-1:0];
			square_wave_en <= pwdata[CTRL_SQUARE_WAVE_ENABLE];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event flags: set by pulses, cleared by reading, new event beats the clear
	assign ev_in[EV_PERIODIC] = periodic_tick;
	assign ev_in[EV_ALARM]    = alarm_match;
	assign ev_in[EV_UPDATE]   = update_done;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_flag_r <= FLAG_RST;
		end else if (reset_clear) begin
			ev_flag_r <= FLAG_RST;
		end else if (flag_read) begin
			ev_flag_r <= ev_in;
		end else begin
			ev_flag_r <= ev_flag_r | ev_in;
		end
	end

	// summary flag follows any enabled flag, sticky until the flag read
	assign summary_set = |((ev_flag_r | ev_in) & int_en_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			summary_r <= 1'b0;
		end else if (reset_clear) begin
			summary_r <= 1'b0;
		end else if (flag_read) begin
			summary_r <= |(ev_in & int_en_r);
		end else if (summary_set) begin
			summary_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// open-drain request line: value fixed low, enable pulls it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req_n_out <= 1'b0;
			irq_req_n_oe  <= 1'b0;
		end else begin
			irq_req_n_out <= 1'b0;
			if (reset_clear) begin
				irq_req_n_oe <= 1'b0;
			end else begin
				irq_req_n_oe <= |(ev_flag_r & int_en_r) & ~flag_read;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status: request raised, reset pin entry, power fail entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_reset_d_r  <= 1'b0;
			power_fail_d_r <= 1'b0;
		end else begin
			dev_reset_d_r  <= dev_reset;
			power_fail_d_r <= power_fail_s;
		end
	end

	assign is_event[IS_REQUEST]    = summary_set & ~summary_r & ~reset_clear;
	assign is_event[IS_DEV_RESET]  = dev_reset & ~dev_reset_d_r;
	assign is_event[IS_POWER_FAIL] = power_fail_s & ~power_fail_d_r;

	// write one clears; an event in the same cycle keeps its bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_r <= ISTAT_RST;
		end else if (wr_now && paddr == ADDR_ISTAT) begin
			istat_r <= (istat_r & ~pwdata[NUM_IS-1:0]) | is_event;
		end else begin
			istat_r <= istat_r | is_event;
		end
	end

	// mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			imask_r <= IMASK_RST;
		end else if (wr_now && paddr == ADDR_IMASK) begin
			imask_r <= pwdata[NUM_IS-1:0];
		end
	end

	// level interrupt to the system
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			intr <= 1'b0;
		end else begin
			intr <= |(istat_r & imask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timekeeping count; the reset pin has no path here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_count_r <= '0;
		end else if (wr_now && paddr == ADDR_TIME) begin
			time_count_r <= pwdata;
		end else if (update_done) begin
			time_count_r <= time_count_r + DATA_W'(1);
		end
	end

	// general ram; kept across bus and pin resets alike
	always_ff @(posedge pclk) begin
		if (wr_now && is_ram && paddr[1:0] == 2'h0) begin
			ram_r[ram_idx] <= pwdata;
		end
	end

endmodule

`default_nettype wire

// >>> dv/rtc_irq_sva.sv
// assertions on the rtc reset and request-line block
// assumes it is bound to rtc_irq_ctrl; one clock domain
`default_nettype none

module rtc_irq_sva
	import rtc_irq_pkg::*;
(
	input wire logic                           pclk,
	input wire logic                           presetn,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [rtc_irq_pkg::ADDR_W-1:0] paddr,
	input wire logic                           pready,
	input wire logic                           pslverr,
	input wire logic                           reset_pin_n,
	input wire logic                           power_fail_pin,
	input wire logic                           periodic_tick,
	input wire logic                           alarm_match,
	input wire logic                           update_done,
	input wire logic                           irq_req_n_out,
	input wire logic                           irq_req_n_oe,
	input wire logic                           square_wave_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////
	// helper terms: committed access, any event, flag read, reset with good supply
	logic done;
	logic ev;
	logic rd_clr;
	logic quiet;
	assign done   = psel && penable && pready && !pslverr;
	assign ev     = periodic_tick || alarm_match || update_done;
	assign rd_clr = done && !pwrite && paddr == ADDR_FLAGS;
	assign quiet  = !reset_pin_n && !power_fail_pin;

	////////////////////////////////////////////////////////////////////////////
	// request line, reset pin and power-fail behaviour
	a_line_low_only: assert property (irq_req_n_out == 1'b0)
		else $error("request line driven high");
	a_reset_frees_line: assert property (quiet[*7] |-> !irq_req_n_oe)
		else $error("request line held during reset");
	a_reset_sqw_off: assert property (quiet[*7] |-> !square_wave_en)
		else $error("square wave on during reset");
	a_reset_refuses: assert property ((!reset_pin_n)[*8] ##0 (psel && penable && pready) |-> pslverr)
		else $error("access accepted during reset");
	a_pfail_refuses: assert property (power_fail_pin[*8] ##0 (psel && penable && pready) |-> pslverr)
		else $error("access accepted in power fail");
	a_pfail_keeps_sqw: assert property ((reset_pin_n && power_fail_pin)[*8] |-> $stable(square_wave_en))
		else $error("control changed in power fail");
	a_read_frees_line: assert property (rd_clr && !ev |-> ##2 !irq_req_n_oe)
		else $error("line not released after flag read");
	a_line_holds: assert property (reset_pin_n[*8] ##0 (irq_req_n_oe && !done && !$past(done)
		&& !$past(done, 2)) |=> irq_req_n_oe)
		else $error("line released while pending");

	c_line_pulled: cover property ($rose(irq_req_n_oe));
	c_flag_read: cover property (rd_clr);
	c_refused: cover property (psel && penable && pready && pslverr);
endmodule

`default_nettype wire

// >>> dv/host_model.sv
// host side: interrupt input with a pull-up, and the reset source
// assumes no other driver shares the request line
`default_nettype none

module host_model (
	input  wire logic reset_req,
	input  wire logic irq_req_n_out,
	input  wire logic irq_req_n_oe,
	output var  logic reset_pin_n,
	output var  logic irq_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// reset source; the bench holds it well past the four-cycle synchroniser delay
	assign reset_pin_n = !reset_req;
	// wired line: pulled up unless the device sinks it
	assign irq_line = irq_req_n_oe ? irq_req_n_out : 1'b1;
endmodule

`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the rtc reset and request-line block
// assumes package, design, host model and checker compiled before it
`default_nettype none

module testbench;
	import rtc_irq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic              pf, tick, alarm, upd, od, oe, sqw, intr, reset_req, rst_n, line;
	int                miscompares, checks, cyc;

	always #2.5 pclk = !pclk;

	rtc_irq_ctrl #(.POWERUP_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reset_pin_n(rst_n), .power_fail_pin(pf),
		.periodic_tick(tick), .alarm_match(alarm), .update_done(upd), .irq_req_n_out(od),
		.irq_req_n_oe(oe), .square_wave_en(sqw), .intr(intr));

	host_model i_host (.reset_req(reset_req), .irq_req_n_out(od), .irq_req_n_oe(oe),
		.reset_pin_n(rst_n), .irq_line(line));

	////////////////////////////////////////////////////////////////////////////
	// compare, bus and event tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmpb(input logic got, input logic exp, input string what);
		cmp({31'h0, got}, {31'h0, exp}, what);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// this wait ends when pready is seen high, or else at the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		cmpb(e, ee, "write error");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		cmpb(e, ee, "read error");
		cmp(q, x, "read data");
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic pulse(input int i);
		@(posedge pclk);
		tick <= (i == 0);
		alarm <= (i == 1);
		upd <= (i == 2);
		@(posedge pclk);
		tick <= 1'b0;
		alarm <= 1'b0;
		upd <= 1'b0;
	endtask

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog on the whole run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			$display("MISMATCH t=%0t timeout", $time);
			print_verdict;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, pf, tick, alarm, upd, reset_req} = '0;
		paddr = '0;
		pwdata = '0;
		tk(16);
		presetn <= 1'b1;
		tk(16);
		rd(ADDR_CTRL, 32'h0, 1'b0);
		rd(ADDR_IMASK, 32'h0, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
		$display("test registers done");
		wr(ADDR_CTRL, 32'hf, 1'b0);
		for (int i = 0; i < 3; i++) begin
			pulse(i);
			tk(3);
			cmpb(line, 1'b0, "line low");
			rd(ADDR_STATE, 32'hc, 1'b0);
			rd(ADDR_FLAGS, (32'h1 << i) | 32'h80, 1'b0);
			tk(3);
			cmpb(line, 1'b1, "line released");
		end
		wr(ADDR_CTRL, 32'h0, 1'b0);
		pulse(0);
		tk(3);
		cmpb(line, 1'b1, "line idle when disabled");
		rd(ADDR_FLAGS, 32'h1, 1'b0);
		$display("test request line done");
		wr(ADDR_ISTAT, 32'h7, 1'b0);
		rd(ADDR_ISTAT, 32'h0, 1'b0);
		wr(ADDR_IMASK, 32'h1, 1'b0);
		wr(ADDR_CTRL, 32'h1, 1'b0);
		pulse(0);
		tk(4);
		cmpb(intr, 1'b1, "intr raised");
		wr(ADDR_ISTAT, 32'h1, 1'b0);
		tk(2);
		cmpb(intr, 1'b0, "intr cleared");
		wr(ADDR_IMASK, 32'h0, 1'b0);
		rd(ADDR_FLAGS, 32'h81, 1'b0);
		pulse(0);
		tk(4);
		cmpb(intr, 1'b0, "intr masked");
		rd(ADDR_ISTAT, 32'h1, 1'b0);
		rd(ADDR_FLAGS, 32'h81, 1'b0);
		$display("test interrupt done");
		wr(ADDR_TIME, 32'h1234, 1'b0);
		wr(ADDR_RAM + 8'h4, 32'ha5a5_0f0f, 1'b0);
		wr(ADDR_CTRL, 32'hf, 1'b0);
		pulse(1);
		tk(2);
		reset_req <= 1'b1;
		tk(8);
		cmpb(line, 1'b1, "line free in reset");
		cmpb(sqw, 1'b0, "square wave off");
		rd(ADDR_CTRL, 32'h0, 1'b1);
		wr(ADDR_CTRL, 32'hf, 1'b1);
		reset_req <= 1'b0;
		tk(8);
		rd(ADDR_CTRL, 32'h0, 1'b0);
		rd(ADDR_FLAGS, 32'h0, 1'b0);
		rd(ADDR_TIME, 32'h1234, 1'b0);
		rd(ADDR_RAM + 8'h4, 32'ha5a5_0f0f, 1'b0);
		rd(ADDR_ISTAT, 32'h3, 1'b0);
		$display("test reset pin done");
		wr(ADDR_CTRL, 32'h8, 1'b0);
		pf <= 1'b1;
		tk(8);
		wr(ADDR_CTRL, 32'h0, 1'b1);
		rd(ADDR_RAM + 8'h4, 32'h0, 1'b1);
		cmpb(sqw, 1'b1, "square wave kept");
		pf <= 1'b0;
		tk(8);
		rd(ADDR_CTRL, 32'h8, 1'b0);
		rd(ADDR_ISTAT, 32'h7, 1'b0);
		$display("test power fail done");
		print_verdict;
	end
endmodule

bind rtc_irq_ctrl rtc_irq_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.reset_pin_n(reset_pin_n), .power_fail_pin(power_fail_pin), .periodic_tick(periodic_tick),
	.alarm_match(alarm_match), .update_done(update_done), .irq_req_n_out(irq_req_n_out),
	.irq_req_n_oe(irq_req_n_oe), .square_wave_en(square_wave_en));

`default_nettype wire
